/* include/ocaq_pkg.sv */
// Purpose: shared constants and types for the overcurrent alert qualifier
// Assumes: 200 MHz ref_clk
// Notes:   sense and limit values are unsigned microvolt codes
package ocaq_pkg;

  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned WINDOW_US       = 10;
  localparam int unsigned WINDOW_CYCLES   = WINDOW_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 12;
  localparam int unsigned VAL_W           = 20;
  localparam int unsigned ACC_W           = 32;
  localparam logic [VAL_W-1:0] NOISE_OFFSET_UV = 20'h0_01F4;
  localparam logic [3:0]  RUN_MID         = 4'h5;
  localparam logic [3:0]  RUN_LONG        = 4'hA;
  localparam logic [3:0]  RUN_SHORT       = 4'h1;

  // three-state select: floating, ground, supply
  typedef enum logic [1:0] {
    OCAQ_SEL_10US,
    OCAQ_SEL_50US,
    OCAQ_SEL_100US
  } ocaq_sel_t;

  typedef struct packed {
    logic       pull_up;
    logic       pull_down;
  } ocaq_sense3_t;

endpackage : ocaq_pkg

/* hw/ocaq_window.sv */
// Purpose: free-running comparison window with input averaging
// Assumes: sense_uv already synchronous to ref_clk
// Notes:   average compared as sum against limit times window length
`timescale 1ns/1ps
module ocaq_window
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic [ocaq_pkg::VAL_W-1:0] sense_uv,
  input  wire logic [ocaq_pkg::VAL_W-1:0] limit_uv,
  output logic                          win_end_r,
  output logic                          over_r
);

  localparam logic [ocaq_pkg::CNT_W-1:0] LAST = ocaq_pkg::CNT_W'(ocaq_pkg::WINDOW_CYCLES - 1);

  logic [ocaq_pkg::CNT_W-1:0] cnt_r;
  logic [ocaq_pkg::CNT_W-1:0] cnt_nxt;
  logic [ocaq_pkg::ACC_W-1:0] acc_r;
  logic [ocaq_pkg::ACC_W-1:0] acc_nxt;
  logic [ocaq_pkg::ACC_W-1:0] sum;
  logic [ocaq_pkg::ACC_W-1:0] lim_sum;
  logic                       win_end_nxt;
  logic                       over_nxt;

  // window never aligns to the input: runs from reset regardless
  always_comb
  begin
    sum         = acc_r + ocaq_pkg::ACC_W'(sense_uv);
    lim_sum     = ocaq_pkg::ACC_W'(limit_uv) * ocaq_pkg::ACC_W'(ocaq_pkg::WINDOW_CYCLES);
    win_end_nxt = (cnt_r == LAST);
    over_nxt    = over_r;
    cnt_nxt     = cnt_r + 1'b1;
    acc_nxt     = sum;
    if (cnt_r == LAST)
    begin
      cnt_nxt  = '0;
      acc_nxt  = '0;
      over_nxt = (sum > lim_sum);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_r     <= '0;
      acc_r     <= '0;
      win_end_r <= 1'b0;
      over_r    <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      acc_r     <= acc_nxt;
      win_end_r <= win_end_nxt;
      over_r    <= over_nxt;
    end
  end

endmodule : ocaq_window

/* hw/ocaq_top.sv */
// Purpose: qualify overcurrent alerts over consecutive comparison windows
// Assumes: select and hold pins are asynchronous; sense and limit codes are synchronous
// Notes:   alert is open-drain, oe low drives the pin low
`timescale 1ns/1ps
module ocaq_top
(
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic [ocaq_pkg::VAL_W-1:0] sense_uv,
  input  wire logic [ocaq_pkg::VAL_W-1:0] limit_uv,
  input  wire ocaq_pkg::ocaq_sense3_t     delay_sel,
  input  wire logic                       hold_sel,
  output logic                            alert_n_o,
  output logic                            alert_n_oe,
  output logic                            overcurrent_r
);

  // delay_sel.pull_up: pin reads high with weak pull-up; pull_down: reads high with weak pull-down
  ocaq_pkg::ocaq_sense3_t sel_s1_r;
  ocaq_pkg::ocaq_sense3_t sel_s2_r;
  logic                   hold_s1_r;
  logic                   hold_s2_r;
  ocaq_pkg::ocaq_sel_t    mode_r;
  ocaq_pkg::ocaq_sel_t    mode_nxt;
  logic                   latch_r;
  logic                   latch_nxt;
  logic [3:0]             run_r;
  logic [3:0]             run_nxt;
  logic [3:0]             need;
  logic                   alert_r;
  logic                   alert_nxt;
  logic [ocaq_pkg::VAL_W-1:0] eff_limit;
  logic                   win_end;
  logic                   over;

  ocaq_window u_window
  (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .sense_uv  (sense_uv),
    .limit_uv  (eff_limit),
    .win_end_r (win_end),
    .over_r    (over)
  );

  always_comb
  begin
    // floating pin follows the pull, driven pin ignores it
    if (sel_s2_r.pull_up && !sel_s2_r.pull_down)
      mode_nxt = ocaq_pkg::OCAQ_SEL_10US;
    else if (sel_s2_r.pull_up)
      mode_nxt = ocaq_pkg::OCAQ_SEL_100US;
    else
      mode_nxt = ocaq_pkg::OCAQ_SEL_50US;
    latch_nxt = hold_s2_r;
    // limit code is the trip level; in 10 us mode only, a noise term lowers the effective limit when the limit is above it
    if (mode_r == ocaq_pkg::OCAQ_SEL_10US && limit_uv > ocaq_pkg::NOISE_OFFSET_UV)
      eff_limit = limit_uv - ocaq_pkg::NOISE_OFFSET_UV;
    else
      eff_limit = limit_uv;
    case (mode_r)
      ocaq_pkg::OCAQ_SEL_10US:  need = ocaq_pkg::RUN_SHORT;
      ocaq_pkg::OCAQ_SEL_50US:  need = ocaq_pkg::RUN_MID;
      ocaq_pkg::OCAQ_SEL_100US: need = ocaq_pkg::RUN_LONG;
      default:                  need = ocaq_pkg::RUN_SHORT;
    endcase
  end

  // window result is used one cycle after win_end pulse; over was updated together with the pulse and holds
  logic win_seen_r;
  logic trip;

  always_comb
  begin
    run_nxt   = run_r;
    alert_nxt = alert_r;
    trip      = win_seen_r && over && (run_r + 4'h1 >= need);
    if (win_seen_r)
    begin
      if (over)
      begin
        run_nxt = (run_r >= need) ? need : run_r + 4'h1;
        if (trip)
          alert_nxt = 1'b1;
      end
      else
      begin
        run_nxt = 4'h0;
        if (!latch_r)
          alert_nxt = 1'b0;
      end
    end
    // latch cleared by a low level on the hold select; a trip in the same cycle wins
    if (latch_r && !hold_s2_r && !trip)
      alert_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sel_s1_r   <= '0;
      sel_s2_r   <= '0;
      hold_s1_r  <= 1'b0;
      hold_s2_r  <= 1'b0;
      mode_r     <= ocaq_pkg::OCAQ_SEL_10US;
      latch_r    <= 1'b0;
      run_r      <= 4'h0;
      alert_r    <= 1'b0;
      win_seen_r <= 1'b0;
      alert_n_o  <= 1'b0;
      alert_n_oe <= 1'b1;
      overcurrent_r <= 1'b0;
    end
    else
    begin
      sel_s1_r   <= delay_sel;
      sel_s2_r   <= sel_s1_r;
      hold_s1_r  <= hold_sel;
      hold_s2_r  <= hold_s1_r;
      mode_r     <= mode_nxt;
      latch_r    <= latch_nxt;
      run_r      <= run_nxt;
      alert_r    <= alert_nxt;
      win_seen_r <= win_end;
      alert_n_o  <= 1'b0;
      alert_n_oe <= ~alert_nxt;
      overcurrent_r <= alert_nxt;
    end
  end

  // window result as seen by the run counter
  sequence s_win_over;
    win_seen_r && over;
  endsequence

  sequence s_win_under;
    win_seen_r && !over;
  endsequence

  property p_short_trip;
    @(posedge ref_clk) disable iff (reset)
      (s_win_over ##0 mode_r == ocaq_pkg::OCAQ_SEL_10US) |=> !alert_n_oe;
  endproperty
  a_short_trip: assert property (p_short_trip) else $error("short trip missed");

  property p_idle_high;
    @(posedge ref_clk) disable iff (reset)
      (!win_seen_r && !(latch_r && !hold_s2_r)) |=> $stable(alert_r);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("alert moved off window end");

  property p_mid_run;
    @(posedge ref_clk) disable iff (reset)
      ($rose(alert_r) && mode_r == ocaq_pkg::OCAQ_SEL_50US) |-> $past(run_r) >= 4'h4;
  endproperty
  a_mid_run: assert property (p_mid_run) else $error("mid trip too early");

  property p_run_clear;
    @(posedge ref_clk) disable iff (reset)
      s_win_under |=> run_r == 4'h0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run not cleared");

  property p_long_run;
    @(posedge ref_clk) disable iff (reset)
      ($rose(alert_r) && mode_r == ocaq_pkg::OCAQ_SEL_100US) |-> $past(run_r) >= 4'h9;
  endproperty
  a_long_run: assert property (p_long_run) else $error("long trip too early");

  property p_noise;
    @(posedge ref_clk) disable iff (reset)
      (mode_r != ocaq_pkg::OCAQ_SEL_10US) |-> eff_limit == limit_uv;
  endproperty
  a_noise: assert property (p_noise) else $error("offset in long mode");

  property p_transparent_release;
    @(posedge ref_clk) disable iff (reset)
      (win_seen_r && !over && !latch_r) |=> alert_n_oe;
  endproperty
  a_transparent_release: assert property (p_transparent_release) else $error("no release");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (reset)
      (alert_r && latch_r && hold_s2_r) |=> alert_r;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

  property p_latch_keep;
    @(posedge ref_clk) disable iff (reset)
      (s_win_under ##0 (alert_r && latch_r && hold_s2_r)) |=> !alert_n_oe;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch released by quiet window");

  property p_latch_clear;
    @(posedge ref_clk) disable iff (reset)
      (latch_r && !hold_s2_r && !trip) |=> alert_n_oe;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch clear ignored");

  property p_sel_ground;
    @(posedge ref_clk) disable iff (reset)
      (!sel_s2_r.pull_up && !sel_s2_r.pull_down) |=> mode_r == ocaq_pkg::OCAQ_SEL_50US;
  endproperty
  a_sel_ground: assert property (p_sel_ground) else $error("ground select misread");

  property p_sel_supply;
    @(posedge ref_clk) disable iff (reset)
      (sel_s2_r.pull_up && sel_s2_r.pull_down) |=> mode_r == ocaq_pkg::OCAQ_SEL_100US;
  endproperty
  a_sel_supply: assert property (p_sel_supply) else $error("supply select misread");

  // both outputs launch from the same next value, so they never disagree
  property p_out_mirror;
    @(posedge ref_clk) disable iff (reset)
      overcurrent_r == !alert_n_oe;
  endproperty
  a_out_mirror: assert property (p_out_mirror) else $error("outputs disagree");

endmodule : ocaq_top

/* tb/ocaq_ctrl_model.sv */
// Purpose: controller input pin on the far side of the alert line
// Assumes: open-drain alert, oe low pulls the line low
// Notes:   pull-up sets the level whenever the device lets go
`timescale 1ns/1ps
module ocaq_ctrl_model
(
  input  wire logic alert_n_o,
  input  wire logic alert_n_oe,
  input  wire logic latch_req,
  output logic      pin_level,
  output logic      hold_sel
);
  // never trust alert_n_o while released: pull-up wins
  assign pin_level = alert_n_oe ? 1'b1 : alert_n_o;
  // low level is both transparent select and latch clear
  assign hold_sel  = latch_req;
endmodule : ocaq_ctrl_model

/* tb/tb.sv */
// Purpose: self-checking bench for the alert qualifier
// Assumes: window of WINDOW_CYCLES, alert 2 cycles after window end
// Notes:   window phase unknown, so trip times are checked as ranges
`timescale 1ns/1ps
module tb;
  localparam int W = ocaq_pkg::WINDOW_CYCLES;
  logic                       ref_clk;
  logic                       reset;
  logic                       latch_req;
  logic                       hold_sel;
  logic                       pin;
  logic                       a_o;
  logic                       a_oe;
  logic                       oc;
  logic [ocaq_pkg::VAL_W-1:0] sense;
  logic [ocaq_pkg::VAL_W-1:0] limit;
  ocaq_pkg::ocaq_sense3_t     sel;
  int                         err_count = 0;
  int                         n_checks = 0;
  int                         cyc = 0;

  ocaq_top dut_u (.ref_clk(ref_clk), .reset(reset), .sense_uv(sense), .limit_uv(limit), .delay_sel(sel),
    .hold_sel(hold_sel), .alert_n_o(a_o), .alert_n_oe(a_oe), .overcurrent_r(oc));
  ocaq_ctrl_model ctrl_u (.alert_n_o(a_o), .alert_n_oe(a_oe), .latch_req(latch_req), .pin_level(pin),
    .hold_sel(hold_sel));

  task automatic final_report;
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // range check: window phase against the stimulus is unknown
  task automatic wait_pin(input logic lvl, input int lo, input int hi, input string name);
    int n;
    n = 0;
    while (pin !== lvl && n <= hi)
    begin
      step(1);
      n++;
    end
    chk(name, (n >= lo && n <= hi), 1);
    chk("overcurrent", oc, !lvl);
  endtask : wait_pin

  task automatic release_alert;
    sense = '0;
    wait_pin(1'b1, 1, 2 * W + 8, "release");
  endtask : release_alert

  task automatic t_short;
    step(2 * W + 10);
    chk("short quiet", pin, 1'b1);
    sense = 20'h0_02BC;
    wait_pin(1'b0, 0, 2 * W + 8, "short trip");
    release_alert();
  endtask : t_short

  task automatic t_mid;
    sel = 2'b00;
    step(4);
    sense = 20'h0_02BC;
    step(5 * W + 10);
    chk("mid no offset", pin, 1'b1);
    sense = 20'h0_044C;
    wait_pin(1'b0, 4 * W, 5 * W + 8, "mid trip");
    release_alert();
  endtask : t_mid

  task automatic t_run;
    sense = 20'h0_044C;
    step(3 * W + W / 2);
    sense = '0;
    step(2 * W);
    chk("run cleared", pin, 1'b1);
    sense = 20'h0_044C;
    // a part window may fall short, so up to five full windows follow it
    wait_pin(1'b0, 4 * W, 6 * W + 8, "run restart");
    release_alert();
  endtask : t_run

  task automatic t_long;
    sel = 2'b11;
    step(4);
    sense = 20'h0_044C;
    wait_pin(1'b0, 9 * W, 10 * W + 8, "long trip");
    release_alert();
  endtask : t_long

  task automatic t_latch;
    sel = 2'b10;
    latch_req = 1'b1;
    step(4);
    sense = 20'h0_044C;
    wait_pin(1'b0, 0, 2 * W + 8, "latch trip");
    sense = '0;
    step(3 * W);
    chk("latch hold", pin, 1'b0);
    latch_req = 1'b0;
    wait_pin(1'b1, 1, 2 * W + 8, "latch clear");
  endtask : t_latch

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ceiling covers about 43 windows of traffic plus margin
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    reset = 1'b1;
    sense = 20'h0_0190;
    limit = 20'h0_03E8;
    sel = 2'b10;
    latch_req = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("reset pin", pin, 1'b1);
    chk("reset overcurrent", oc, 1'b0);
    reset = 1'b0;
    step(4);
    t_short();
    t_mid();
    t_run();
    t_long();
    t_latch();
    final_report();
  end
endmodule : tb
